// ===== rtl/wss_edge_latch.v
// Falling-edge event latches with enable gating and clear on read
`timescale 1ns/1ps
module wss_edge_latch #(
    parameter N = 8
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Per-bit pins, set enables and clear pulses
    input  wire [N-1:0] pin,
    input  wire [N-1:0] set_en,
    input  wire [N-1:0] clr,
    // Latched state and new-event pulses
    output wire [N-1:0] stat,
    output wire [N-1:0] set_pulse
);

genvar i;
generate
    for (i = 0; i < N; i = i + 1) begin : g_bit
        reg  prev_ff;
        reg  stat_ff;
        wire fall;
        wire nxt_stat;
        // Previous level resets low, so a pin held low at release is no edge
        assign fall         = prev_ff & ~pin[i] & set_en[i];
        assign nxt_stat     = fall | (stat_ff & ~clr[i]);
        assign stat[i]      = stat_ff;
        assign set_pulse[i] = fall & ~stat_ff;
        always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                prev_ff <= 1'b0;
                stat_ff <= 1'b0;
            end else begin
                prev_ff <= pin[i];
                stat_ff <= nxt_stat;
            end
        end
    end
endgenerate

endmodule

// ===== rtl/wss_map.vh
// Register map, field positions, reset values and encodings for the wake status and SMI enable block
`ifndef WSS_MAP_VH
`define WSS_MAP_VH

// Register indices; byte address is four times the index
`define WSS_IDX_WAKE_EN_ONE      8'hB0
`define WSS_IDX_WAKE_EN_TWO      8'hB1
`define WSS_IDX_STATUS_ONE       8'hB2
`define WSS_IDX_STATUS_TWO       8'hB3
`define WSS_IDX_ROUTE_EN_ONE     8'hB4
`define WSS_IDX_ROUTE_EN_TWO     8'hB5
`define WSS_IDX_SMI_SRC_VIEW     8'hB6
`define WSS_IDX_IRQ_STATUS       8'hBA
`define WSS_IDX_IRQ_MASK         8'hBB

// Byte addresses on the bus
`define WSS_ADDR_WAKE_EN_ONE     12'h2C0
`define WSS_ADDR_WAKE_EN_TWO     12'h2C4
`define WSS_ADDR_STATUS_ONE      12'h2C8
`define WSS_ADDR_STATUS_TWO      12'h2CC
`define WSS_ADDR_ROUTE_EN_ONE    12'h2D0
`define WSS_ADDR_ROUTE_EN_TWO    12'h2D4
`define WSS_ADDR_SMI_SRC_VIEW    12'h2D8
`define WSS_ADDR_IRQ_STATUS      12'h2E8
`define WSS_ADDR_IRQ_MASK        12'h2EC

// Reset values
`define WSS_RST_WAKE_EN_ONE      8'h00
`define WSS_RST_WAKE_EN_TWO      8'h80
`define WSS_RST_STATUS           8'h00
`define WSS_RST_ROUTE_EN         8'h00
`define WSS_RST_IRQ              4'h0

// Implemented bits of the second wake enable, and wake-capable bits of the second status register
`define WSS_WAKE_EN_TWO_MASK     8'hD3
`define WSS_STATUS_TWO_WAKE_MASK 8'h13

// Field positions, status one
`define WSS_S1_GROUP_ONE         4
`define WSS_S1_GROUP_TWO         5
`define WSS_S1_RTC_ALARM         7
// Field positions, status two
`define WSS_S2_UART_ONE_RX       0
`define WSS_S2_UART_TWO_RX       1
`define WSS_S2_BUTTON            2
`define WSS_S2_SECOND_ALARM      4
// Field position, second route enable
`define WSS_R2_PIN_ENABLE        7

// Event bits of the interrupt status register
`define WSS_EV_STATUS_ONE        0
`define WSS_EV_STATUS_TWO        1
`define WSS_EV_SMI_RISE          2
`define WSS_EV_POWER_UP          3

// Bus encoding and number of pin edge latches
`define WSS_HTRANS_NONSEQ_BIT    1
`define WSS_NUM_PIN_EDGES        8

`endif

// ===== rtl/wss_top.v
// Wake-up status, wake enables and SMI routing registers behind an AHB-Lite slave
`timescale 1ns/1ps
`include "wss_map.vh"
module wss_top (
    // Clock and reset
    input  wire        CLK,
    input  wire        RST_N,
    // AHB-Lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire [31:0] HRDATA,
    output wire        HREADYOUT,
    output wire        HRESP,
    // Wake pins and internal wake signals
    input  wire        UART_ONE_RING_WAKE,
    input  wire        UART_TWO_RING_WAKE,
    input  wire        KEYBOARD_CLOCK_WAKE,
    input  wire        MOUSE_CLOCK_WAKE,
    input  wire        INFRARED_RX_TWO_WAKE,
    input  wire        UART_ONE_RX_WAKE,
    input  wire        UART_TWO_RX_WAKE,
    input  wire        BUTTON_PRESS_N,
    input  wire        RTC_ALARM,
    input  wire        SECOND_ALARM_WAKE,
    input  wire        GROUP_IRQ_ONE,
    input  wire        GROUP_IRQ_TWO,
    // Peripheral interrupt sources for SMI routing
    input  wire        DISK_IFACE_IRQ,
    input  wire        PARALLEL_IRQ,
    input  wire        UART_TWO_IRQ,
    input  wire        UART_ONE_IRQ,
    input  wire        FLOPPY_IRQ,
    input  wire        WATCHDOG_IRQ,
    // Power request and SMI pin
    output wire        POWER_UP_REQUEST_N,
    output wire        SYSTEM_MGMT_IRQ_N_O,
    output wire        SYSTEM_MGMT_IRQ_N_OE,
    // Interrupt to the host
    output wire        IRQ
);

// Bus phase state
localparam [1:0] ST_IDLE  = 2'b00;
localparam [1:0] ST_WRITE = 2'b01;
localparam [1:0] ST_RWAIT = 2'b10;
localparam [1:0] ST_RDONE = 2'b11;

reg  [1:0]  state_ff;
reg  [1:0]  nxt_state;
reg  [11:0] addr_ff;
reg  [31:0] hrdata_ff;

reg  [7:0]  wake_en_one_ff;
reg  [7:0]  wake_en_two_ff;
reg  [7:0]  route_en_one_ff;
reg  [7:0]  route_en_two_ff;
reg  [3:0]  irq_status_ff;
reg  [3:0]  irq_mask_ff;
reg         rtc_alarm_stat_ff;
reg         second_alarm_stat_ff;
reg         group_smi_ff;
reg         power_req_ff;
reg         irq_ff;

wire        access;
wire        rd_capture;
wire        wr_commit;
wire        clr_status_one;
wire        clr_status_two;
wire [7:0]  wr_byte;

wire [7:0]  pin_vec;
wire [7:0]  pin_set_en;
wire [7:0]  pin_clr;
wire [7:0]  pin_stat;
wire [7:0]  pin_new;

wire [7:0]  status_one;
wire [7:0]  status_two;
wire [7:0]  smi_src;
wire        nxt_group_smi;
wire        nxt_power_req;
wire        power_req_one;
wire        power_req_two;
wire        nxt_rtc_alarm_stat;
wire        nxt_second_alarm_stat;
wire [3:0]  irq_event;
wire [3:0]  irq_w1c;
wire [3:0]  nxt_irq_status;

reg  [7:0]  rd_mux;

// Address phase is taken when selected, NONSEQ/SEQ and the bus is ready
assign access    = HSEL & HTRANS[`WSS_HTRANS_NONSEQ_BIT] & HREADY;
// Only a read data phase stalls; a write completes in its first data cycle
assign HREADYOUT = (state_ff != ST_RWAIT);
assign HRESP     = 1'b0;
assign HRDATA    = hrdata_ff;

// Reads take one wait state so the data come from a flop after any prior write
// A read right behind a write therefore sees the new value
always @* begin
    nxt_state = state_ff;
    case (state_ff)
        ST_IDLE, ST_WRITE, ST_RDONE: begin
            if (access && HWRITE) begin
                nxt_state = ST_WRITE;
            end else if (access) begin
                nxt_state = ST_RWAIT;
            end else begin
                nxt_state = ST_IDLE;
            end
        end
        ST_RWAIT: begin
            nxt_state = ST_RDONE;
        end
        default: begin
            nxt_state = ST_IDLE;
        end
    endcase
end

assign rd_capture     = (state_ff == ST_RWAIT);
assign wr_commit      = (state_ff == ST_WRITE);
assign wr_byte        = HWDATA[7:0];
// The clear lands on the capture edge, so a read returns the very bits that it clears
assign clr_status_one = rd_capture & (addr_ff == `WSS_ADDR_STATUS_ONE);
assign clr_status_two = rd_capture & (addr_ff == `WSS_ADDR_STATUS_TWO);

// Address is kept for the decode in the data phase
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        state_ff <= ST_IDLE;
        addr_ff  <= 12'h000;
    end else begin
        state_ff <= nxt_state;
        if (access) begin
            addr_ff <= HADDR[11:0];
        end
    end
end

// Falling-edge pins; each set except the button's is gated by its wake enable
assign pin_vec = {BUTTON_PRESS_N, UART_TWO_RX_WAKE, UART_ONE_RX_WAKE, INFRARED_RX_TWO_WAKE,
                  MOUSE_CLOCK_WAKE, KEYBOARD_CLOCK_WAKE, UART_TWO_RING_WAKE, UART_ONE_RING_WAKE};
// Button has no wake enable and always latches
assign pin_set_en = {1'b1, wake_en_two_ff[`WSS_S2_UART_TWO_RX], wake_en_two_ff[`WSS_S2_UART_ONE_RX],
                     wake_en_one_ff[6], wake_en_one_ff[3:0]};
// Bits 7:5 belong to status two, bits 4:0 to status one
assign pin_clr    = {{3{clr_status_two}}, {5{clr_status_one}}};

// A new edge in the capture cycle of a clearing read wins over the clear
wss_edge_latch #(
    .N (`WSS_NUM_PIN_EDGES)
) u_edges (
    .clk       (CLK),
    .rst_n     (RST_N),
    .pin       (pin_vec),
    .set_en    (pin_set_en),
    .clr       (pin_clr),
    .stat      (pin_stat),
    .set_pulse (pin_new)
);

// Alarm bits set while their source is high and their wake enable is set, and clear on read unless set again
assign nxt_rtc_alarm_stat    = (RTC_ALARM & wake_en_one_ff[`WSS_S1_RTC_ALARM])
                               | (rtc_alarm_stat_ff & ~clr_status_one);
assign nxt_second_alarm_stat = (SECOND_ALARM_WAKE & wake_en_two_ff[`WSS_S2_SECOND_ALARM])
                               | (second_alarm_stat_ff & ~clr_status_two);

// Status one: latched pins, direct group interrupts, alarm
assign status_one = {rtc_alarm_stat_ff,
                     pin_stat[4],
                     GROUP_IRQ_TWO,
                     GROUP_IRQ_ONE,
                     pin_stat[3:2],
                     pin_stat[1],
                     pin_stat[0]};

// Status two: receive data, button, second alarm; reserved bits are zero
assign status_two = {3'h0,
                     second_alarm_stat_ff,
                     1'b0,
                     pin_stat[7],
                     pin_stat[6:5]};

// SMI sources in route-enable bit order
assign smi_src = {WATCHDOG_IRQ, GROUP_IRQ_ONE, GROUP_IRQ_TWO, FLOPPY_IRQ,
                  UART_ONE_IRQ, UART_TWO_IRQ, PARALLEL_IRQ, DISK_IFACE_IRQ};
// Group SMI is registered so the pin cannot glitch while sources change
assign nxt_group_smi = |(smi_src & route_en_one_ff);

// Power request from enabled sources only; the button latch is left out
// Group bits show raw in status one but wake the system only when enabled
assign power_req_one = |(status_one & wake_en_one_ff);
assign power_req_two = |(status_two & wake_en_two_ff & `WSS_STATUS_TWO_WAKE_MASK);
assign nxt_power_req = power_req_one | power_req_two;

// Interrupt events and write-one-to-clear status, set winning
assign irq_event[`WSS_EV_STATUS_ONE] = |pin_new[4:0]
                                       | (nxt_rtc_alarm_stat & ~rtc_alarm_stat_ff);
assign irq_event[`WSS_EV_STATUS_TWO] = |pin_new[7:5]
                                       | (nxt_second_alarm_stat & ~second_alarm_stat_ff);
assign irq_event[`WSS_EV_SMI_RISE]   = nxt_group_smi & ~group_smi_ff;
assign irq_event[`WSS_EV_POWER_UP]   = nxt_power_req & ~power_req_ff;
assign irq_w1c        = (wr_commit && addr_ff == `WSS_ADDR_IRQ_STATUS) ? wr_byte[3:0] : 4'h0;
// The mask gates only IRQ; status records every event
// IRQ is taken from the next status so it rises with the bit that it reports
assign nxt_irq_status = irq_event | (irq_status_ff & ~irq_w1c);

always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        rtc_alarm_stat_ff    <= 1'b0;
        second_alarm_stat_ff <= 1'b0;
        group_smi_ff         <= 1'b0;
        power_req_ff         <= 1'b0;
        irq_status_ff        <= `WSS_RST_IRQ;
        irq_ff               <= 1'b0;
    end else begin
        rtc_alarm_stat_ff    <= nxt_rtc_alarm_stat;
        second_alarm_stat_ff <= nxt_second_alarm_stat;
        group_smi_ff         <= nxt_group_smi;
        power_req_ff         <= nxt_power_req;
        irq_status_ff        <= nxt_irq_status;
        irq_ff               <= |(nxt_irq_status & irq_mask_ff);
    end
end

// Software-written registers
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        wake_en_one_ff  <= `WSS_RST_WAKE_EN_ONE;
        wake_en_two_ff  <= `WSS_RST_WAKE_EN_TWO;
        route_en_one_ff <= `WSS_RST_ROUTE_EN;
        route_en_two_ff <= `WSS_RST_ROUTE_EN;
        irq_mask_ff     <= `WSS_RST_IRQ;
    end else if (wr_commit) begin
        case (addr_ff)
            `WSS_ADDR_WAKE_EN_ONE: begin
                wake_en_one_ff <= wr_byte;
            end
            `WSS_ADDR_WAKE_EN_TWO: begin
                wake_en_two_ff <= wr_byte & `WSS_WAKE_EN_TWO_MASK;
            end
            `WSS_ADDR_ROUTE_EN_ONE: begin
                route_en_one_ff <= wr_byte;
            end
            `WSS_ADDR_ROUTE_EN_TWO: begin
                route_en_two_ff <= wr_byte;
            end
            `WSS_ADDR_IRQ_MASK: begin
                irq_mask_ff <= wr_byte[3:0];
            end
            `WSS_ADDR_STATUS_ONE, `WSS_ADDR_STATUS_TWO, `WSS_ADDR_SMI_SRC_VIEW: begin
                // Read-only registers drop writes
                irq_mask_ff <= irq_mask_ff;
            end
            default: begin
                irq_mask_ff <= irq_mask_ff;
            end
        endcase
    end
end

// Read mux; status one and two are read-only and clear their latches on this read
always @* begin
    case (addr_ff)
        `WSS_ADDR_WAKE_EN_ONE: begin
            rd_mux = wake_en_one_ff;
        end
        `WSS_ADDR_WAKE_EN_TWO: begin
            rd_mux = wake_en_two_ff;
        end
        `WSS_ADDR_STATUS_ONE: begin
            rd_mux = status_one;
        end
        `WSS_ADDR_STATUS_TWO: begin
            rd_mux = status_two;
        end
        `WSS_ADDR_ROUTE_EN_ONE: begin
            rd_mux = route_en_one_ff;
        end
        `WSS_ADDR_ROUTE_EN_TWO: begin
            rd_mux = route_en_two_ff;
        end
        `WSS_ADDR_SMI_SRC_VIEW: begin
            rd_mux = smi_src;
        end
        `WSS_ADDR_IRQ_STATUS: begin
            rd_mux = {4'h0, irq_status_ff};
        end
        `WSS_ADDR_IRQ_MASK: begin
            rd_mux = {4'h0, irq_mask_ff};
        end
        default: begin
            rd_mux = 8'h00;
        end
    endcase
end

// Read data is captured once per read and holds until the next read
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        hrdata_ff <= 32'h00000000;
    end else if (rd_capture) begin
        hrdata_ff <= {24'h000000, rd_mux};
    end
end

// Outputs
// The pin is driven only while pin enable is set; otherwise it floats
assign POWER_UP_REQUEST_N   = ~power_req_ff;
assign SYSTEM_MGMT_IRQ_N_O  = ~group_smi_ff;
assign SYSTEM_MGMT_IRQ_N_OE = route_en_two_ff[`WSS_R2_PIN_ENABLE];
assign IRQ                  = irq_ff;

endmodule

// ===== sim/wss_chk.sv
// Concurrent checks on the wake status and SMI routing block ports
`timescale 1ns/1ps
`include "wss_map.vh"
module wss_chk (
    // Clock and reset
    input wire        CLK,
    input wire        RST_N,
    // Register bus
    input wire        HSEL,
    input wire [31:0] HADDR,
    input wire [1:0]  HTRANS,
    input wire        HWRITE,
    input wire        HREADY,
    input wire [31:0] HRDATA,
    input wire        HREADYOUT,
    input wire        HRESP,
    // SMI sources
    input wire        DISK_IFACE_IRQ,
    input wire        PARALLEL_IRQ,
    input wire        UART_TWO_IRQ,
    input wire        UART_ONE_IRQ,
    input wire        FLOPPY_IRQ,
    input wire        GROUP_IRQ_TWO,
    input wire        GROUP_IRQ_ONE,
    input wire        WATCHDOG_IRQ,
    // Block outputs
    input wire        POWER_UP_REQUEST_N,
    input wire        SYSTEM_MGMT_IRQ_N_O,
    input wire        SYSTEM_MGMT_IRQ_N_OE,
    input wire        IRQ
);
    wire       take  = HSEL && HTRANS[1] && HREADY;
    wire       rd_s1 = take && !HWRITE && HADDR[11:0] == `WSS_ADDR_STATUS_ONE;
    wire       rd_s2 = take && !HWRITE && HADDR[11:0] == `WSS_ADDR_STATUS_TWO;
    wire [7:0] src   = {WATCHDOG_IRQ, GROUP_IRQ_ONE, GROUP_IRQ_TWO, FLOPPY_IRQ,
                        UART_ONE_IRQ, UART_TWO_IRQ, PARALLEL_IRQ, DISK_IFACE_IRQ};
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_resp_okay: assert property (HRESP == 1'b0) else $error("error response seen");
    a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait wrong");
    a_write_nowait: assert property (take && HWRITE |=> HREADYOUT) else $error("write stalled");
    a_upper_zero: assert property (take && !HWRITE |-> ##2 HRDATA[31:8] == 24'h0) else $error("upper bits set");
    a_reserved_zero: assert property (rd_s2 |-> ##2 HRDATA[7:5] == 3'h0 && !HRDATA[3])
        else $error("reserved status bit set");
    a_group_status: assert property ((rd_s1 && $stable({GROUP_IRQ_TWO, GROUP_IRQ_ONE}))
        ##1 $stable({GROUP_IRQ_TWO, GROUP_IRQ_ONE})[*2] |-> HRDATA[5:4] == {GROUP_IRQ_TWO, GROUP_IRQ_ONE})
        else $error("group bits do not follow sources");
    a_smi_idle: assert property ((src == 8'h00)[*2] |-> SYSTEM_MGMT_IRQ_N_O) else $error("SMI without source");
    a_reset_quiet: assert property ($rose(RST_N) |-> POWER_UP_REQUEST_N && SYSTEM_MGMT_IRQ_N_O
        && !SYSTEM_MGMT_IRQ_N_OE && !IRQ) else $error("outputs active after reset");

    c_read: cover property (take && !HWRITE ##2 HREADYOUT);
    c_smi: cover property (!SYSTEM_MGMT_IRQ_N_O && SYSTEM_MGMT_IRQ_N_OE);
    c_power: cover property (!POWER_UP_REQUEST_N);
    c_irq: cover property (IRQ);
endmodule

bind wss_top wss_chk u_wss_chk (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .DISK_IFACE_IRQ(DISK_IFACE_IRQ), .PARALLEL_IRQ(PARALLEL_IRQ), .UART_TWO_IRQ(UART_TWO_IRQ),
    .UART_ONE_IRQ(UART_ONE_IRQ), .FLOPPY_IRQ(FLOPPY_IRQ), .GROUP_IRQ_TWO(GROUP_IRQ_TWO),
    .GROUP_IRQ_ONE(GROUP_IRQ_ONE), .WATCHDOG_IRQ(WATCHDOG_IRQ), .POWER_UP_REQUEST_N(POWER_UP_REQUEST_N),
    .SYSTEM_MGMT_IRQ_N_O(SYSTEM_MGMT_IRQ_N_O), .SYSTEM_MGMT_IRQ_N_OE(SYSTEM_MGMT_IRQ_N_OE), .IRQ(IRQ));

// ===== sim/wss_tb.sv
// Self-checking testbench for the wake status and SMI routing block
`timescale 1ns/1ps
`include "wss_map.vh"
module tb;
    reg        clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        hsel = 1'b0, hwrite = 1'b0, bt = 1'b1, rtc = 1'b0, al2 = 1'b0;
    reg [1:0]  htrans = 2'b00;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    reg [6:0]  wk = 7'h7F;
    reg [7:0]  src = 8'h00;
    wire [31:0] hrdata;
    wire       hreadyout, pwr_n, smi_n, smi_oe, irq;
    integer    err_count = 0, checked = 0, i;

    always #2 clk = ~clk;

    wss_top u_wss_top (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(), .UART_ONE_RING_WAKE(wk[0]), .UART_TWO_RING_WAKE(wk[1]),
        .KEYBOARD_CLOCK_WAKE(wk[2]), .MOUSE_CLOCK_WAKE(wk[3]), .INFRARED_RX_TWO_WAKE(wk[4]),
        .UART_ONE_RX_WAKE(wk[5]), .UART_TWO_RX_WAKE(wk[6]), .BUTTON_PRESS_N(bt), .RTC_ALARM(rtc),
        .SECOND_ALARM_WAKE(al2), .GROUP_IRQ_ONE(src[6]), .GROUP_IRQ_TWO(src[5]), .DISK_IFACE_IRQ(src[0]),
        .PARALLEL_IRQ(src[1]), .UART_TWO_IRQ(src[2]), .UART_ONE_IRQ(src[3]), .FLOPPY_IRQ(src[4]),
        .WATCHDOG_IRQ(src[7]), .POWER_UP_REQUEST_N(pwr_n), .SYSTEM_MGMT_IRQ_N_O(smi_n),
        .SYSTEM_MGMT_IRQ_N_OE(smi_oe), .IRQ(irq));

    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    // Ready and read data are taken just before the edge that samples them
    task wait_rdy;
        reg r;
        begin
            r = 1'b0;
            while (r !== 1'b1) begin
                @(negedge clk);
                r = hreadyout;
                rd = hrdata;
                @(posedge clk);
            end
        end
    endtask

    task bus(input w, input [11:0] a, input [7:0] d);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            htrans <= 2'b10;
            hwrite <= w;
            haddr <= {20'h0, a};
            wait_rdy;
            htrans <= 2'b00;
            hwdata <= {24'h0, d};
            wait_rdy;
        end
    endtask

    task rd_chk(input string name, input [11:0] a, input [7:0] exp);
        begin
            bus(1'b0, a, 8'h00);
            check(name, rd, {24'h0, exp});
        end
    endtask

    task settle;
        begin
            repeat (3) @(posedge clk);
            @(negedge clk);
        end
    endtask

    // One-cycle low pulse on the chosen wake pins and, when b is set, the button
    task fall(input [6:0] m, input b);
        begin
            @(posedge clk);
            wk <= wk & ~m;
            bt <= ~b;
            @(posedge clk);
            wk <= 7'h7F;
            bt <= 1'b1;
        end
    endtask

    task t_reset;
        begin
            check("power", pwr_n, 1);
            check("smi oe", smi_oe, 0);
            rd_chk("wake en two", `WSS_ADDR_WAKE_EN_TWO, 8'h80);
            rd_chk("status one", `WSS_ADDR_STATUS_ONE, 8'h00);
            rd_chk("status two", `WSS_ADDR_STATUS_TWO, 8'h00);
            rd_chk("route one", `WSS_ADDR_ROUTE_EN_ONE, 8'h00);
            bus(1'b1, 12'hFFC, 8'h5A);
            rd_chk("unmapped", 12'hFFC, 8'h00);
            $display("test reset done");
        end
    endtask

    task t_stat1;
        begin
            bus(1'b1, `WSS_ADDR_WAKE_EN_ONE, 8'hFF);
            @(posedge clk);
            rtc <= 1'b1;
            src[6] <= 1'b1;
            fall(7'h1F, 1'b0);
            settle;
            check("power", pwr_n, 0);
            @(posedge clk);
            rtc <= 1'b0;
            rd_chk("status one", `WSS_ADDR_STATUS_ONE, 8'hDF);
            rd_chk("status one", `WSS_ADDR_STATUS_ONE, 8'h10);
            @(posedge clk);
            src <= 8'h20;
            settle;
            rd_chk("status one", `WSS_ADDR_STATUS_ONE, 8'h20);
            src <= 8'h00;
            bus(1'b1, `WSS_ADDR_WAKE_EN_ONE, 8'h00);
            fall(7'h01, 1'b0);
            settle;
            check("power", pwr_n, 1);
            rd_chk("status one", `WSS_ADDR_STATUS_ONE, 8'h00);
            $display("test status one done");
        end
    endtask

    task t_stat2;
        begin
            bus(1'b1, `WSS_ADDR_WAKE_EN_TWO, 8'hFF);
            rd_chk("wake en two", `WSS_ADDR_WAKE_EN_TWO, 8'hD3);
            bus(1'b1, `WSS_ADDR_WAKE_EN_TWO, 8'h93);
            @(posedge clk);
            al2 <= 1'b1;
            fall(7'h60, 1'b1);
            @(posedge clk);
            al2 <= 1'b0;
            settle;
            check("power", pwr_n, 0);
            rd_chk("status two", `WSS_ADDR_STATUS_TWO, 8'h17);
            rd_chk("status two", `WSS_ADDR_STATUS_TWO, 8'h00);
            bus(1'b1, `WSS_ADDR_WAKE_EN_TWO, 8'h80);
            fall(7'h00, 1'b1);
            settle;
            check("power", pwr_n, 1);
            rd_chk("status two", `WSS_ADDR_STATUS_TWO, 8'h04);
            $display("test status two done");
        end
    endtask

    task t_route;
        begin
            bus(1'b1, `WSS_ADDR_ROUTE_EN_TWO, 8'h80);
            settle;
            check("smi oe", smi_oe, 1);
            for (i = 0; i < 8; i = i + 1) begin
                bus(1'b1, `WSS_ADDR_ROUTE_EN_ONE, 8'h01 << i);
                @(posedge clk);
                src <= ~(8'h01 << i);
                settle;
                check("smi off", smi_n, 1);
                @(posedge clk);
                src <= 8'h01 << i;
                settle;
                check("smi on", smi_n, 0);
            end
            rd_chk("smi view", `WSS_ADDR_SMI_SRC_VIEW, 8'h80);
            src <= 8'h00;
            rd_chk("route one", `WSS_ADDR_ROUTE_EN_ONE, 8'h80);
            bus(1'b1, `WSS_ADDR_ROUTE_EN_TWO, 8'h00);
            settle;
            check("smi oe", smi_oe, 0);
            $display("test routing done");
        end
    endtask

    task t_irq;
        begin
            bus(1'b1, `WSS_ADDR_IRQ_STATUS, 8'h0F);
            bus(1'b1, `WSS_ADDR_IRQ_MASK, 8'h00);
            bus(1'b1, `WSS_ADDR_WAKE_EN_ONE, 8'h01);
            fall(7'h01, 1'b0);
            settle;
            check("irq masked", irq, 0);
            bus(1'b1, `WSS_ADDR_IRQ_MASK, 8'h01);
            settle;
            check("irq", irq, 1);
            bus(1'b1, `WSS_ADDR_IRQ_STATUS, 8'h01);
            settle;
            check("irq cleared", irq, 0);
            rd_chk("irq status", `WSS_ADDR_IRQ_STATUS, 8'h08);
            rd_chk("status one", `WSS_ADDR_STATUS_ONE, 8'h01);
            $display("test interrupt done");
        end
    endtask

    // Ring two falls on the capture edge of a status one read
    task t_race;
        begin
            bus(1'b1, `WSS_ADDR_WAKE_EN_ONE, 8'h02);
            @(posedge clk);
            hsel   <= 1'b1;
            hwrite <= 1'b0;
            htrans <= 2'b10;
            haddr  <= {20'h0, `WSS_ADDR_STATUS_ONE};
            wait_rdy;
            htrans <= 2'b00;
            wk[1]  <= 1'b0;
            wait_rdy;
            wk[1]  <= 1'b1;
            check("status one race", rd, 32'h00000000);
            rd_chk("status one kept", `WSS_ADDR_STATUS_ONE, 8'h02);
            $display("test clear race done");
        end
    endtask

    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count = err_count + 1;
        give_verdict;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_stat1;
        t_stat2;
        t_route;
        t_irq;
        t_race;
        give_verdict;
    end
endmodule
